// >>> hw/eppv_pkg.sv
package eppv_pkg;
  localparam int IMAGE_BITS = 192;
  localparam int WORD_BITS = 16;
  localparam int WORD_COUNT = IMAGE_BITS / WORD_BITS;
  localparam int CLK_MHZ = 250;
  // setup window for entering programming mode, in ms
  localparam real SETUP_MIN_MS = 3.5;
  localparam real SETUP_MAX_MS = 4.5;
  localparam int SETUP_MIN_CYC = int'($ceil(SETUP_MIN_MS * 1000.0 * CLK_MHZ));
  localparam int SETUP_MAX_CYC = int'($floor(SETUP_MAX_MS * 1000.0 * CLK_MHZ));
  localparam int SETUP_CNT_W = 21;
  localparam int BIT_CNT_W = 9;
  localparam logic [BIT_CNT_W-1:0] VERIFY_FIRST = 9'h0c0;
  localparam logic [BIT_CNT_W-1:0] VERIFY_END = 9'h180;
  localparam logic [3:0] LAST_WORD = 4'hb;
  localparam logic [3:0] LAST_BIT = 4'hf;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_SETUP = 5'b00010,
    ST_ERASE = 5'b00100,
    ST_PROG = 5'b01000,
    ST_VERIFY = 5'b10000
  } eppv_state_t;
endpackage

// >>> hw/eppv_port.sv
// What this block does
// - image is 192 bits, stored internally
// - clock high 3.5-4.5 ms, data high enters
// - entry bulk-writes memory; programmer waits 4.0 ms
// - bulk write clears every location to zero
// - 16-bit words, clock line shifts data line
// - each word triggers internal write; 50 ms pause
// - verify clocks stored bits out on data line
// - no readback without full programming after erase
// - one verify pass, then blocked until reprogrammed
`timescale 1ns/1ps
`default_nettype none
module eppv_port #(
  parameter int SETUP_MIN = eppv_pkg::SETUP_MIN_CYC,
  parameter int SETUP_MAX = eppv_pkg::SETUP_MAX_CYC
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic button_clock_line_a,
  input wire logic tx_data_in,
  output logic tx_data_out,
  output logic tx_data_oe,
  output logic prog_active,
  output logic verify_active
);
  // the count trails the clock rise by one cycle, so both bounds sit one lower
  localparam logic [eppv_pkg::SETUP_CNT_W-1:0] MIN_C = eppv_pkg::SETUP_CNT_W'(SETUP_MIN - 1);
  localparam logic [eppv_pkg::SETUP_CNT_W-1:0] MAX_C = eppv_pkg::SETUP_CNT_W'(SETUP_MAX - 1);

  eppv_pkg::eppv_state_t state_reg;
  logic [eppv_pkg::SETUP_CNT_W-1:0] setup_cnt_reg;
  logic [3:0] word_idx_reg;
  logic link_hold_reg;
  logic btn_meta_reg, btn_sync_reg, btn_prev_reg;
  logic dat_meta_reg, dat_sync_reg;
  logic wt_meta_reg, wt_sync_reg, wt_prev_reg;
  logic dt_meta_reg, dt_sync_reg, dt_prev_reg;
  logic [eppv_pkg::WORD_BITS-1:0] mem [0:eppv_pkg::WORD_COUNT-1];
  logic link_rst_n;
  logic word_evt, done_evt;

  // link-side registers and the combinational verify bit index
  logic [eppv_pkg::BIT_CNT_W-1:0] bit_cnt_reg;
  logic [eppv_pkg::WORD_BITS-1:0] shift_reg;
  logic [eppv_pkg::WORD_BITS-1:0] word_hold_reg;
  logic word_tgl_reg;
  logic done_tgl_reg;
  logic out_reg;
  logic oe_reg;
  logic [eppv_pkg::BIT_CNT_W-1:0] vidx;

  // synchronisers into the core domain
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      btn_meta_reg <= 1'b0;
      btn_sync_reg <= 1'b0;
      btn_prev_reg <= 1'b0;
      dat_meta_reg <= 1'b0;
      dat_sync_reg <= 1'b0;
      wt_meta_reg <= 1'b0;
      wt_sync_reg <= 1'b0;
      wt_prev_reg <= 1'b0;
      dt_meta_reg <= 1'b0;
      dt_sync_reg <= 1'b0;
      dt_prev_reg <= 1'b0;
    end
    else
    begin
      btn_meta_reg <= button_clock_line_a;
      btn_sync_reg <= btn_meta_reg;
      btn_prev_reg <= btn_sync_reg;
      dat_meta_reg <= tx_data_in;
      dat_sync_reg <= dat_meta_reg;
      wt_meta_reg <= word_tgl_reg;
      wt_sync_reg <= wt_meta_reg;
      wt_prev_reg <= wt_sync_reg;
      dt_meta_reg <= done_tgl_reg;
      dt_sync_reg <= dt_meta_reg;
      dt_prev_reg <= dt_sync_reg;
    end
  end

  assign word_evt = wt_sync_reg ^ wt_prev_reg;
  assign done_evt = dt_sync_reg ^ dt_prev_reg;

  // entry sequence, word count and single verify pass
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg <= eppv_pkg::ST_IDLE;
      setup_cnt_reg <= '0;
      word_idx_reg <= 4'h0;
      link_hold_reg <= 1'b1;
    end
    else
    begin
      unique case (state_reg)
        eppv_pkg::ST_IDLE:
        begin
          setup_cnt_reg <= '0;
          if (btn_sync_reg && !btn_prev_reg && !dat_sync_reg)
          begin
            state_reg <= eppv_pkg::ST_SETUP;
          end
        end
        eppv_pkg::ST_SETUP:
        begin
          setup_cnt_reg <= setup_cnt_reg + 1'b1;
          if (!btn_sync_reg || setup_cnt_reg > MAX_C)
          begin
            state_reg <= eppv_pkg::ST_IDLE;
          end
          else if (dat_sync_reg)
          begin
            // data rising too early aborts; within window enters
            state_reg <= (setup_cnt_reg >= MIN_C) ? eppv_pkg::ST_ERASE : eppv_pkg::ST_IDLE;
          end
        end
        eppv_pkg::ST_ERASE:
        begin
          // link released only here: the only road to readback
          word_idx_reg <= 4'h0;
          link_hold_reg <= 1'b0;
          state_reg <= eppv_pkg::ST_PROG;
        end
        eppv_pkg::ST_PROG:
        begin
          if (word_evt)
          begin
            word_idx_reg <= word_idx_reg + 1'b1;
            if (word_idx_reg == eppv_pkg::LAST_WORD)
            begin
              state_reg <= eppv_pkg::ST_VERIFY;
            end
          end
        end
        eppv_pkg::ST_VERIFY:
        begin
          if (done_evt)
          begin
            // holding the link in reset blocks any second pass
            link_hold_reg <= 1'b1;
            state_reg <= eppv_pkg::ST_IDLE;
          end
        end
        default:
        begin
          link_hold_reg <= 1'b1;
          state_reg <= eppv_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // image store
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < eppv_pkg::WORD_COUNT; i++)
      begin
        mem[i] <= '0;
      end
    end
    else if (state_reg == eppv_pkg::ST_ERASE)
    begin
      for (int i = 0; i < eppv_pkg::WORD_COUNT; i++)
      begin
        mem[i] <= '0;
      end
    end
    else if (state_reg == eppv_pkg::ST_PROG && word_evt)
    begin
      // word_hold is stable for 16 link clocks, far beyond the sync delay
      mem[word_idx_reg] <= word_hold_reg;
    end
  end

  // verify still counts as an active programming session
  assign prog_active = state_reg[3] | state_reg[4];
  assign verify_active = state_reg[4];

  // link is held in reset outside programming; the hold flop is glitch-free
  // and releases while the programmer keeps the clock still
  assign link_rst_n = nrst & ~link_hold_reg;
  assign vidx = bit_cnt_reg - eppv_pkg::VERIFY_FIRST;

  // link domain: shift in words, then shift the image back out once
  always_ff @(posedge button_clock_line_a or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      bit_cnt_reg <= '0;
      shift_reg <= '0;
      word_hold_reg <= '0;
      word_tgl_reg <= 1'b0;
      done_tgl_reg <= 1'b0;
      out_reg <= 1'b0;
      oe_reg <= 1'b0;
    end
    else if (bit_cnt_reg < eppv_pkg::VERIFY_FIRST)
    begin
      // lsb first, one bit per rising clock edge
      shift_reg[bit_cnt_reg[3:0]] <= tx_data_in;
      bit_cnt_reg <= bit_cnt_reg + 1'b1;
      if (bit_cnt_reg[3:0] == eppv_pkg::LAST_BIT)
      begin
        word_hold_reg <= {tx_data_in, shift_reg[14:0]};
        word_tgl_reg <= ~word_tgl_reg;
      end
    end
    else if (bit_cnt_reg < eppv_pkg::VERIFY_END)
    begin
      // image is quasi-static here: no writes after the twelfth word
      out_reg <= mem[vidx[7:4]][vidx[3:0]];
      oe_reg <= 1'b1;
      bit_cnt_reg <= bit_cnt_reg + 1'b1;
    end
    else
    begin
      // saturates: no further readback without a new entry
      if (oe_reg)
      begin
        done_tgl_reg <= ~done_tgl_reg;
      end
      oe_reg <= 1'b0;
      out_reg <= 1'b0;
    end
  end

  assign tx_data_out = out_reg;
  assign tx_data_oe = oe_reg;
endmodule
`default_nettype wire

// >>> sim/eppv_port_props.sv
`timescale 1ns/1ps
`default_nettype none
module eppv_port_props #(
  parameter int SETUP_MIN = 40,
  parameter int SETUP_MAX = 60
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic button_clock_line_a,
  input wire logic tx_data_in,
  input wire logic tx_data_out,
  input wire logic tx_data_oe,
  input wire logic prog_active,
  input wire logic verify_active
);
  logic [8:0] lcnt;
  logic [191:0] img;
  int hi_cnt;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // link edges of the current session; both sides update on the same edge
  always_ff @(posedge button_clock_line_a or negedge nrst)
  begin
    if (!nrst)
      lcnt <= 9'h000;
    else
      lcnt <= prog_active ? lcnt + 9'h001 : 9'h000;
  end
  always_ff @(posedge button_clock_line_a)
  begin
    if (prog_active && lcnt < 9'h0c0)
      img[lcnt] <= tx_data_in;
  end
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      hi_cnt <= 0;
    else
      hi_cnt <= button_clock_line_a ? hi_cnt + 1 : 0;
  end
  // two sync stages, the check and the erase put the rise four cycles after data
  property p_entry; $rose(prog_active) |->
    hi_cnt >= SETUP_MIN + 4 && hi_cnt <= SETUP_MAX + 4; endproperty
  a_entry: assert property (p_entry) else $error("entry outside window");
  property p_oe_count; tx_data_oe == (lcnt > 9'h0c0 && lcnt < 9'h181); endproperty
  a_oe_count: assert property (p_oe_count) else $error("readback edges");
  property p_data; tx_data_oe |-> tx_data_out == img[lcnt - 9'h0c1]; endproperty
  a_data: assert property (p_data) else $error("readback bit");
  property p_oe_verify; tx_data_oe |-> verify_active; endproperty
  a_oe_verify: assert property (p_oe_verify) else $error("drive outside verify");
  property p_verify_prog; verify_active |-> prog_active; endproperty
  a_verify_prog: assert property (p_verify_prog) else $error("verify unarmed");
  property p_twelve; $rose(verify_active) |-> lcnt == 9'h0c0; endproperty
  a_twelve: assert property (p_twelve) else $error("verify early");
  property p_done; $fell(tx_data_oe) |-> ##[1:8] !prog_active; endproperty
  a_done: assert property (p_done) else $error("no return to idle");
  property p_out_low; !tx_data_oe |-> !tx_data_out; endproperty
  a_out_low: assert property (p_out_low) else $error("data out not low");
endmodule
bind eppv_port eppv_port_props #(.SETUP_MIN(SETUP_MIN), .SETUP_MAX(SETUP_MAX))
  eppv_port_props_inst (.core_clk(core_clk), .nrst(nrst),
  .button_clock_line_a(button_clock_line_a), .tx_data_in(tx_data_in),
  .tx_data_out(tx_data_out), .tx_data_oe(tx_data_oe), .prog_active(prog_active),
  .verify_active(verify_active));
`default_nettype wire

// >>> sim/eppv_prog_model.sv
`timescale 1ns/1ps
`default_nettype none
module eppv_prog_model (
  output logic clk_line,
  output logic pd,
  output logic poe,
  input wire logic line
);
  initial
  begin
    clk_line = 0;
    pd = 0;
    poe = 1;
  end
  task idle;
    clk_line = 0;
    pd = 0;
    #100;
  endtask
  task enter(input int hi);
    poe = 1;
    clk_line = 1;
    #(hi * 4) pd = 1;
    #200 clk_line = 0;
    #15;
  endtask
  task word(input logic [15:0] w);
    for (int i = 0; i < 16; i++)
    begin
      pd = w[i];
      #15 clk_line = 1;
      #15 clk_line = 0;
    end
    #60;
  endtask
  task rd(output logic b);
    poe = 0;
    #15 clk_line = 1;
    #12 b = line;
    #3 clk_line = 0;
  endtask
endmodule
`default_nettype wire

// >>> sim/eppv_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module eppv_port_tb;
  logic core_clk = 0, nrst = 0, clk_line, pd, poe, out, oe, pa, va, b;
  logic [15:0] w;
  logic q[$];
  int num_errors = 0, tests_run = 0, n;
  int bad[4] = '{20, 39, 61, 80};
  wire logic line = oe ? out : poe & pd; // pull-down when released
  always #2 core_clk = ~core_clk;
  eppv_port #(.SETUP_MIN(40), .SETUP_MAX(60)) eppv_port_inst (.core_clk(core_clk), .nrst(nrst),
    .button_clock_line_a(clk_line), .tx_data_in(line), .tx_data_out(out), .tx_data_oe(oe),
    .prog_active(pa), .verify_active(va));
  eppv_prog_model eppv_prog_model_inst (.clk_line(clk_line), .pd(pd), .poe(poe), .line(line));
  task chk(string s, logic [15:0] seen, logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s exp %h seen %h", s, exp, seen);
    end
  endtask
  task complete_run;
    if (num_errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task wait_pa(logic v);
    n = 0;
    while (pa !== v && n < 50)
    begin
      @(posedge core_clk);
      n++;
    end
    chk("prog_active", pa, v);
    if (pa !== v)
      complete_run();
  endtask
  initial
  begin
    void'($urandom(65306));
    repeat (8) @(posedge core_clk);
    #1 nrst = 1;
    eppv_prog_model_inst.rd(b);
    chk("unarmed_read", oe, 0);
    eppv_prog_model_inst.idle();
    foreach (bad[i])
    begin
      eppv_prog_model_inst.enter(bad[i]);
      chk("bad_entry", pa, 0);
      eppv_prog_model_inst.idle();
    end
    @(posedge core_clk);
    #1 eppv_prog_model_inst.enter(40 + int'($urandom % 21));
    wait_pa(1);
    for (int k = 0; k < 12; k++)
    begin
      w = 16'($urandom);
      for (int i = 0; i < 16; i++)
        q.push_back(w[i]);
      eppv_prog_model_inst.word(w);
    end
    chk("verify_active", va, 1);
    foreach (q[i])
    begin
      eppv_prog_model_inst.rd(b);
      chk("readback", b, q[i]);
    end
    eppv_prog_model_inst.rd(b);
    chk("oe_after_pass", oe, 0);
    wait_pa(0);
    chk("verify_done", va, 0);
    eppv_prog_model_inst.rd(b);
    chk("second_pass", oe, 0);
    complete_run();
  end
endmodule
`default_nettype wire
